// ==== bfb_pkg.sv ====
// Constants, types and helper functions shared by the burst flash bus behaviour block.
package bfb_pkg;

	localparam int ADDR_W = 19;
	localparam int DATA_W = 16;
	localparam int NUM_SECT = 9;
	localparam int ARRAY_WORDS = 524288;
	localparam int FIFO_DEPTH = 16;

	// Command words for a bus write; CMD_RESET is defined but not decoded by the core.
	localparam logic [15:0] CMD_PROGRAM = 16'h00a0;
	localparam logic [15:0] CMD_ERASE_SETUP = 16'h0080;
	localparam logic [15:0] CMD_SECTOR_ERASE = 16'h0030;
	localparam logic [15:0] CMD_SUSPEND = 16'h00b0;
	localparam logic [15:0] CMD_RESUME = 16'h00d0;
	localparam logic [15:0] CMD_BURST_ON = 16'h00c0;
	localparam logic [15:0] CMD_ASYNC = 16'h00e0;
	localparam logic [15:0] CMD_RESET = 16'h00f0;

	localparam logic [15:0] ERASED_WORD = 16'hffff;
	localparam logic [15:0] PROGRAMMED_WORD = 16'h0000;

	// Timing: core clock period and the address-stable time before sleep.
	localparam int CLK_PERIOD_NS = 40;
	localparam int SLEEP_NS = 300;
	localparam int SLEEP_CYCLES = (SLEEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] SLEEP_CNT = 4'(SLEEP_CYCLES);
	localparam logic [7:0] PROG_VERIFY_CYCLES = 8'h04;
	localparam logic [7:0] ERASE_PULSE_CYCLES = 8'h10;

	// Values after reset.
	localparam logic RST_BURST_MODE = 1'b0;
	localparam logic RST_IDLE_HIGH = 1'b1;

	// Synchroniser bank: address, data, six strobes, reset pin, supply, protect, unprotect.
	localparam int SYNC_W = 53;
	localparam logic [52:0] SYNC_INIT = {19'h00000, 16'h0000, 3'h7, 1'b0, 2'h3, 1'b1,
		1'b0, 9'h000, 1'b0};

	typedef enum logic [3:0] {
		ST_READ,
		ST_PROG_WR,
		ST_PROG_VFY,
		ST_ERA_PRE,
		ST_ERA_PULSE,
		ST_ERA_WIPE,
		ST_ERA_VFY,
		ST_SUSP
	} bfb_state_type;

	// Sector index of a word address, boot sectors at the bottom.
	function automatic logic [3:0] sector_of(input logic [18:0] a);
		if (a < 19'h02000) return 4'h0;
		else if (a < 19'h03000) return 4'h1;
		else if (a < 19'h04000) return 4'h2;
		else if (a < 19'h10000) return 4'h3;
		else if (a < 19'h20000) return 4'h4;
		else if (a < 19'h30000) return 4'h5;
		else if (a < 19'h40000) return 4'h6;
		else if (a < 19'h60000) return 4'h7;
		else return 4'h8;
	endfunction

	function automatic logic [18:0] sector_base(input logic [3:0] s);
		case (s)
			4'h0: return 19'h00000;
			4'h1: return 19'h02000;
			4'h2: return 19'h03000;
			4'h3: return 19'h04000;
			4'h4: return 19'h10000;
			4'h5: return 19'h20000;
			4'h6: return 19'h30000;
			4'h7: return 19'h40000;
			default: return 19'h60000;
		endcase
	endfunction

	function automatic logic [18:0] sector_last(input logic [3:0] s);
		case (s)
			4'h0: return 19'h01fff;
			4'h1: return 19'h02fff;
			4'h2: return 19'h03fff;
			4'h3: return 19'h0ffff;
			4'h4: return 19'h1ffff;
			4'h5: return 19'h2ffff;
			4'h6: return 19'h3ffff;
			4'h7: return 19'h5ffff;
			default: return 19'h7ffff;
		endcase
	endfunction

	// A sector is locked when its protect bit is set and no temporary unprotect is active.
	function automatic logic sector_locked(input logic [18:0] a, input logic [8:0] prot,
		input logic tmp);
		return prot[sector_of(a)] & ~tmp;
	endfunction

	function automatic logic is_busy(input bfb_state_type s);
		return (s != ST_READ) && (s != ST_SUSP);
	endfunction

endpackage

// ==== bfb_sync.sv ====
// Two-stage synchroniser bank for pin inputs entering the core clock domain.
`timescale 1ns/10ps
module bfb_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] P_INIT = '0
) (
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} bfb_sync_type;

	bfb_sync_type q;
	bfb_sync_type d;

	// The first stage feeds only the second stage, never any logic.
	always_comb begin
		d = q;
		d.meta = i_async;
		d.stable = q.meta;
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			q <= {P_INIT, P_INIT};
		end else begin
			q <= d;
		end
	end

	assign o_sync = q.stable;

endmodule

// ==== bfb_fifo.sv ====
// Small synchronous FIFO with valid/ready on both sides and a flush input.
`timescale 1ns/10ps
module bfb_fifo #(
	parameter int W = 16,
	parameter int D = 16
) (
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire logic i_flush,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [W-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [W-1:0] o_out_data
);

	localparam int AW = $clog2(D);
	localparam logic [AW:0] FULL_CNT = (AW + 1)'(D);

	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} bfb_fifo_type;

	bfb_fifo_type q;
	bfb_fifo_type d;
	logic [W-1:0] store [0:D-1];
	logic push;
	logic pop;

	assign o_in_ready = (q.cnt != FULL_CNT);
	assign o_out_valid = (q.cnt != '0);
	assign o_out_data = store[q.rp];
	assign push = i_in_valid & o_in_ready & ~i_flush;
	assign pop = o_out_valid & i_out_ready & ~i_flush;

	// Flush wins over both sides so a reload never mixes old and new words.
	always_comb begin
		d = q;
		if (i_flush) begin
			d = '0;
		end else begin
			if (push) d.wp = AW'(q.wp + 1'b1);
			if (pop) d.rp = AW'(q.rp + 1'b1);
			d.cnt = (AW + 1)'(q.cnt + push - pop);
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// Storage needs no reset; only words counted as valid are ever read out.
	always_ff @(posedge i_core_clk) begin
		if (push) store[q.wp] <= i_in_data;
	end

endmodule

// ==== bfb_core.sv ====
// Burst flash device core: array, command engine, embedded algorithms and burst path.
`timescale 1ns/10ps
module bfb_core (
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire logic [18:0] i_addr,
	input wire logic [15:0] i_data,
	output logic [15:0] o_data,
	output logic o_data_oe_n,
	input wire logic i_chip_en_n,
	input wire logic i_write_en_n,
	input wire logic i_out_en_n,
	input wire logic i_burst_clk,
	input wire logic i_burst_start_load_n,
	input wire logic i_burst_step_n,
	input wire logic i_hw_reset_n,
	input wire logic i_low_supply,
	input wire logic [8:0] i_sector_protect,
	input wire logic i_temp_unprotect,
	output logic o_operation_done_n,
	output logic o_sleep
);

	typedef struct packed {
		bfb_pkg::bfb_state_type state;
		bfb_pkg::bfb_state_type resume_state;
		logic burst_mode;
		logic burst_live;
		logic suspended;
		logic arm_prog;
		logic arm_erase;
		logic [3:0] era_sect;
		logic [18:0] walk_addr;
		logic [18:0] prog_addr;
		logic [15:0] prog_data;
		logic [18:0] fetch_addr;
		logic [15:0] burst_word;
		logic [7:0] timer;
		logic toggle;
		logic [3:0] sleep_cnt;
		logic sleep;
		logic [18:0] last_addr;
		logic we_prev;
		logic oe_prev;
		logic lclk_prev;
		logic [15:0] dout;
		logic oe_n;
		logic done_n;
	} bfb_core_type;

	bfb_core_type q;
	bfb_core_type d;

	// Storage array, one word per address.
	logic [15:0] array_mem [0:bfb_pkg::ARRAY_WORDS-1];

	logic [bfb_pkg::SYNC_W-1:0] sync_out;
	logic [18:0] a_s;
	logic [15:0] d_s;
	logic ce_s, we_s, oe_s, lclk_s, lba_s, baa_s, hwr_s, low_s, tmp_s;
	logic [8:0] prot_s;
	logic we_rise, oe_fall, lclk_rise, cmd_take, drive;
	logic mem_we;
	logic [18:0] mem_wa;
	logic [15:0] mem_wd;
	logic push, flush, pop;
	logic fifo_in_ready, fifo_out_valid;
	logic [15:0] fifo_out_data;
	logic [15:0] rd_async, rd_walk, rd_fetch, rd_prog, status_word;
	logic [18:0] walk_last;

	// Every pin crosses two flip-flops before the core looks at it.
	bfb_sync #(
		.W(bfb_pkg::SYNC_W),
		.P_INIT(bfb_pkg::SYNC_INIT)
	) u_sync (
		.i_core_clk(i_core_clk),
		.i_rst_b(i_rst_b),
		.i_async({i_addr, i_data, i_chip_en_n, i_write_en_n, i_out_en_n, i_burst_clk,
			i_burst_start_load_n, i_burst_step_n, i_hw_reset_n, i_low_supply,
			i_sector_protect, i_temp_unprotect}),
		.o_sync(sync_out)
	);

	assign {a_s, d_s, ce_s, we_s, oe_s, lclk_s, lba_s, baa_s, hwr_s, low_s, prot_s,
		tmp_s} = sync_out;

	// Burst words queue here so a slow link clock stalls fetching instead of losing data.
	bfb_fifo #(
		.W(bfb_pkg::DATA_W),
		.D(bfb_pkg::FIFO_DEPTH)
	) u_fifo (
		.i_core_clk(i_core_clk),
		.i_rst_b(i_rst_b),
		.i_flush(flush),
		.i_in_valid(push),
		.o_in_ready(fifo_in_ready),
		.i_in_data(rd_fetch),
		.o_out_valid(fifo_out_valid),
		.i_out_ready(pop),
		.o_out_data(fifo_out_data)
	);

	// Edge detection on synchronised strobes; the host owns the burst clock.
	assign we_rise = we_s & ~q.we_prev & ~ce_s;
	assign oe_fall = ~oe_s & q.oe_prev & ~ce_s;
	assign lclk_rise = lclk_s & ~q.lclk_prev;
	assign cmd_take = we_rise & ~low_s;
	assign drive = ~ce_s & ~oe_s & we_s;

	// Array read ports for the host, the erase walker, the burst fetch and program verify.
	assign rd_async = array_mem[a_s];
	assign rd_walk = array_mem[q.walk_addr];
	assign rd_fetch = array_mem[q.fetch_addr];
	assign rd_prog = array_mem[q.prog_addr];
	assign walk_last = bfb_pkg::sector_last(q.era_sect);
	assign status_word = {8'h00, (q.state == bfb_pkg::ST_PROG_WR ||
		q.state == bfb_pkg::ST_PROG_VFY) ? ~q.prog_data[7] : 1'b0, q.toggle, 6'h00};

	always_comb begin
		d = q;
		mem_we = 1'b0;
		mem_wa = q.walk_addr;
		mem_wd = bfb_pkg::ERASED_WORD;
		push = 1'b0;
		flush = 1'b0;
		pop = 1'b0;
		d.we_prev = we_s;
		d.oe_prev = oe_s;
		d.lclk_prev = lclk_s;
		d.last_addr = a_s;

		// Sleep only stops the count; read data keeps flowing.
		if (a_s != q.last_addr) begin
			d.sleep_cnt = 4'h0;
			d.sleep = 1'b0;
		end else if (q.sleep_cnt != bfb_pkg::SLEEP_CNT) begin
			d.sleep_cnt = 4'(q.sleep_cnt + 1'b1);
		end else begin
			d.sleep = 1'b1;
		end

		// Each status read toggles bit six while an algorithm runs.
		if (bfb_pkg::is_busy(q.state) && oe_fall) d.toggle = ~q.toggle;

		// Embedded algorithms advance one word per cycle.
		case (q.state)
			bfb_pkg::ST_PROG_WR: begin
				mem_we = 1'b1;
				mem_wa = q.prog_addr;
				mem_wd = rd_prog & q.prog_data;
				d.timer = 8'h00;
				d.state = bfb_pkg::ST_PROG_VFY;
			end
			bfb_pkg::ST_PROG_VFY: begin
				// A cell cannot go from zero to one, so a failed compare cannot be retried.
				d.timer = 8'(q.timer + 1'b1);
				if (q.timer == bfb_pkg::PROG_VERIFY_CYCLES || rd_prog == q.prog_data) begin
					d.state = q.suspended ? bfb_pkg::ST_SUSP : bfb_pkg::ST_READ;
				end
			end
			bfb_pkg::ST_ERA_PRE: begin
				if (rd_walk != bfb_pkg::PROGRAMMED_WORD) begin
					mem_we = 1'b1;
					mem_wd = bfb_pkg::PROGRAMMED_WORD;
				end
				if (q.walk_addr == walk_last) begin
					d.walk_addr = bfb_pkg::sector_base(q.era_sect);
					d.timer = 8'h00;
					d.state = bfb_pkg::ST_ERA_PULSE;
				end else begin
					d.walk_addr = 19'(q.walk_addr + 1'b1);
				end
			end
			bfb_pkg::ST_ERA_PULSE: begin
				d.timer = 8'(q.timer + 1'b1);
				if (q.timer == bfb_pkg::ERASE_PULSE_CYCLES) d.state = bfb_pkg::ST_ERA_WIPE;
			end
			bfb_pkg::ST_ERA_WIPE: begin
				mem_we = 1'b1;
				mem_wd = bfb_pkg::ERASED_WORD;
				if (q.walk_addr == walk_last) begin
					d.walk_addr = bfb_pkg::sector_base(q.era_sect);
					d.state = bfb_pkg::ST_ERA_VFY;
				end else begin
					d.walk_addr = 19'(q.walk_addr + 1'b1);
				end
			end
			bfb_pkg::ST_ERA_VFY: begin
				if (rd_walk != bfb_pkg::ERASED_WORD) begin
					d.walk_addr = bfb_pkg::sector_base(q.era_sect);
					d.timer = 8'h00;
					d.state = bfb_pkg::ST_ERA_PULSE;
				end else if (q.walk_addr == walk_last) begin
					d.state = bfb_pkg::ST_READ;
				end else begin
					d.walk_addr = 19'(q.walk_addr + 1'b1);
				end
			end
			default: begin
			end
		endcase

		// Command capture from a completed bus write.
		if (cmd_take) begin
			if (bfb_pkg::is_busy(q.state)) begin
				if (d_s == bfb_pkg::CMD_SUSPEND && q.state >= bfb_pkg::ST_ERA_PRE) begin
					d.resume_state = q.state;
					d.state = bfb_pkg::ST_SUSP;
					d.suspended = 1'b1;
				end
			end else if (q.arm_prog) begin
				d.arm_prog = 1'b0;
				if (!bfb_pkg::sector_locked(a_s, prot_s, tmp_s) &&
					!(q.suspended && bfb_pkg::sector_of(a_s) == q.era_sect)) begin
					d.prog_addr = a_s;
					d.prog_data = d_s;
					d.state = bfb_pkg::ST_PROG_WR;
				end
			end else if (q.arm_erase && d_s == bfb_pkg::CMD_SECTOR_ERASE) begin
				d.arm_erase = 1'b0;
				if (!bfb_pkg::sector_locked(a_s, prot_s, tmp_s)) begin
					d.era_sect = bfb_pkg::sector_of(a_s);
					d.walk_addr = bfb_pkg::sector_base(bfb_pkg::sector_of(a_s));
					d.state = bfb_pkg::ST_ERA_PRE;
				end
			end else begin
				d.arm_erase = 1'b0;
				case (d_s)
					bfb_pkg::CMD_PROGRAM: d.arm_prog = 1'b1;
					bfb_pkg::CMD_ERASE_SETUP: d.arm_erase = (q.state == bfb_pkg::ST_READ);
					bfb_pkg::CMD_RESUME: begin
						if (q.state == bfb_pkg::ST_SUSP) begin
							d.state = q.resume_state;
							d.suspended = 1'b0;
						end
					end
					bfb_pkg::CMD_BURST_ON: begin
						d.burst_mode = 1'b1;
						d.burst_live = 1'b0;
					end
					bfb_pkg::CMD_ASYNC: begin
						d.burst_mode = 1'b0;
						d.burst_live = 1'b0;
					end
					default: begin
					end
				endcase
			end
		end

		// Burst path: load on a link clock edge, fetch ahead, step out on later edges.
		if (q.burst_mode && !bfb_pkg::is_busy(q.state)) begin
			if (lclk_rise && !lba_s) begin
				d.fetch_addr = a_s;
				d.burst_live = 1'b1;
				flush = 1'b1;
			end else begin
				if (q.burst_live && fifo_in_ready) begin
					push = 1'b1;
					d.fetch_addr = {q.fetch_addr[18:5], 5'(q.fetch_addr[4:0] + 1'b1)};
				end
				if (q.burst_live && lclk_rise && !baa_s && fifo_out_valid) begin
					pop = 1'b1;
					d.burst_word = fifo_out_data;
				end
			end
		end

		// The hardware reset pin overrides the algorithm, command and burst results above.
		if (!hwr_s) begin
			d.state = bfb_pkg::ST_READ;
			d.arm_prog = 1'b0;
			d.arm_erase = 1'b0;
			d.suspended = 1'b0;
			d.burst_mode = bfb_pkg::RST_BURST_MODE;
			d.burst_live = 1'b0;
			flush = 1'b1;
			push = 1'b0;
			pop = 1'b0;
			mem_we = 1'b0;
		end

		// Output word: burst data, status during an algorithm, or the array.
		if (q.burst_mode && q.burst_live) begin
			d.dout = q.burst_word;
		end else if (bfb_pkg::is_busy(q.state) ||
			(q.suspended && bfb_pkg::sector_of(a_s) == q.era_sect)) begin
			d.dout = status_word;
		end else begin
			d.dout = rd_async;
		end
		d.oe_n = ~drive;
		d.done_n = ~bfb_pkg::is_busy(d.state);
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			q <= '0;
			q.we_prev <= bfb_pkg::RST_IDLE_HIGH;
			q.oe_prev <= bfb_pkg::RST_IDLE_HIGH;
			q.oe_n <= bfb_pkg::RST_IDLE_HIGH;
			q.done_n <= bfb_pkg::RST_IDLE_HIGH;
		end else begin
			q <= d;
		end
	end

	// Array contents survive reset, as a flash array would.
	always_ff @(posedge i_core_clk) begin
		if (mem_we) array_mem[mem_wa] <= mem_wd;
	end

	assign o_data = q.dout;
	assign o_data_oe_n = q.oe_n;
	assign o_operation_done_n = q.done_n;
	assign o_sleep = q.sleep;

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_b);

	logic [4:0] fetch_lo;
	logic [13:0] fetch_group;
	assign fetch_lo = q.fetch_addr[4:0];
	assign fetch_group = q.fetch_addr[18:5];

	a_wrap_group_fixed: assert property (push |=> $stable(fetch_group))
		else $error("burst fetch left its 32-word group");
	a_wrap_step_one: assert property (push |=> fetch_lo == 5'($past(fetch_lo) + 1'b1))
		else $error("burst fetch did not step by one with wrap");
	a_hwreset_to_read: assert property (!hwr_s |=> (q.state == bfb_pkg::ST_READ &&
		!q.burst_mode && o_operation_done_n))
		else $error("hardware reset did not return to array read");
	a_busy_pin_prog: assert property ((q.state == bfb_pkg::ST_PROG_WR) |->
		!o_operation_done_n)
		else $error("busy pin not low during program");
	a_done_release: assert property ((q.state == bfb_pkg::ST_ERA_VFY && hwr_s &&
		q.walk_addr == walk_last && rd_walk == bfb_pkg::ERASED_WORD && !cmd_take) |=>
		(q.state == bfb_pkg::ST_READ && o_operation_done_n))
		else $error("finished erase did not release busy");
	a_protect_refuse: assert property ((!bfb_pkg::is_busy(q.state) &&
		d.state == bfb_pkg::ST_PROG_WR) |-> !bfb_pkg::sector_locked(d.prog_addr, prot_s, tmp_s))
		else $error("program accepted into a locked sector");
	a_lowvcc_block: assert property ((low_s && hwr_s && q.state == bfb_pkg::ST_READ) |=>
		(q.state == bfb_pkg::ST_READ && $stable(q.burst_mode) && $stable(q.arm_prog)))
		else $error("write taken during undervoltage");
	a_preprog_zero: assert property ((q.state == bfb_pkg::ST_ERA_PRE && mem_we) |->
		(mem_wd == bfb_pkg::PROGRAMMED_WORD && rd_walk != bfb_pkg::PROGRAMMED_WORD))
		else $error("preprogram wrote a wrong value");
	a_erase_pulse_time: assert property ((q.state == bfb_pkg::ST_ERA_PULSE &&
		q.timer == 8'h00 && hwr_s) |-> (q.state == bfb_pkg::ST_ERA_PULSE)[*8])
		else $error("erase pulse ended too early");
	a_sleep_wake: assert property ((a_s != q.last_addr) |=> !o_sleep)
		else $error("sleep held across an address change");
	a_toggle_poll: assert property ((bfb_pkg::is_busy(q.state) && oe_fall) |=>
		q.toggle != $past(q.toggle))
		else $error("toggle bit did not toggle on status read");
	a_resume_erase: assert property ((q.state == bfb_pkg::ST_SUSP && cmd_take && hwr_s &&
		!q.arm_prog && d_s == bfb_pkg::CMD_RESUME) |=> (q.state == $past(q.resume_state)))
		else $error("resume did not continue the erase");
	a_cmd_capture: assert property ((q.arm_prog && cmd_take &&
		d.state == bfb_pkg::ST_PROG_WR) |=> (q.prog_data == $past(d_s) &&
		q.prog_addr == $past(a_s)))
		else $error("program address or data not captured");
	a_powerup_async: assert property ($rose(i_rst_b) |-> !q.burst_mode)
		else $error("device left reset in burst mode");

endmodule

// ==== bfb_host_model.sv ====
// Host bus model: write cycles, asynchronous reads and framed burst reads.
`timescale 1ns/10ps
module bfb_host_model (
	input wire logic i_core_clk,
	input wire logic [15:0] i_data,
	output logic [18:0] o_addr,
	output logic [15:0] o_data,
	output logic o_chip_en_n,
	output logic o_write_en_n,
	output logic o_out_en_n,
	output logic o_burst_clk,
	output logic o_burst_start_load_n,
	output logic o_burst_step_n
);
	logic [15:0] bw [8];

	// Idle bus at time zero; the link clock stands low outside frames.
	initial begin
		o_addr = 19'h00000;
		o_data = 16'ha5a5;
		o_chip_en_n = 1'b1;
		o_write_en_n = 1'b1;
		o_out_en_n = 1'b1;
		o_burst_clk = 1'b0;
		o_burst_start_load_n = 1'b1;
		o_burst_step_n = 1'b1;
	end

	task automatic idle(input int n);
		repeat (n) @(posedge i_core_clk);
	endtask

	// Address and data stay put past the strobe's rise, then the data lines show the inverse.
	task automatic wr(input logic [18:0] a, input logic [15:0] d);
		@(posedge i_core_clk);
		o_addr <= a;
		o_data <= d;
		o_chip_en_n <= 1'b0;
		o_write_en_n <= 1'b0;
		idle(3);
		o_write_en_n <= 1'b1;
		idle(4);
		o_chip_en_n <= 1'b1;
		o_data <= ~d;
	endtask

	// The gap after a read lets the next read make a fresh output-enable fall.
	task automatic rd(input logic [18:0] a, output logic [15:0] d);
		@(posedge i_core_clk);
		o_addr <= a;
		o_chip_en_n <= 1'b0;
		o_out_en_n <= 1'b0;
		idle(5);
		d = i_data;
		o_chip_en_n <= 1'b1;
		o_out_en_n <= 1'b1;
		idle(3);
	endtask

	// One frame: load rise at a, then n step rises 320 ns apart, word taken late.
	// The step strobe goes low only before a rise that follows, then stays low until the frame ends.
	task automatic burst(input logic [18:0] a, input int n);
		@(posedge i_core_clk);
		o_addr <= a;
		o_chip_en_n <= 1'b0;
		o_out_en_n <= 1'b0;
		o_burst_start_load_n <= 1'b0;
		for (int i = 0; i <= n; i++) begin
			idle(3);
			o_burst_clk <= 1'b1;
			idle(5);
			if (i > 0) bw[i-1] = i_data;
			o_burst_clk <= 1'b0;
			o_burst_start_load_n <= 1'b1;
			if (i < n) begin
				o_burst_step_n <= 1'b0;
			end
		end
		o_burst_step_n <= 1'b1;
		o_chip_en_n <= 1'b1;
		o_out_en_n <= 1'b1;
	endtask
endmodule

// ==== burst_flash_bus_behaviour_tb.sv ====
// Self-checking testbench for the burst flash core, driven through the host bus model.
`timescale 1ns/10ps
module burst_flash_bus_behaviour_tb;
	logic i_core_clk = 1'b0;
	logic i_rst_b = 1'b0;
	logic i_hw_reset_n = 1'b1;
	logic i_low_supply = 1'b0;
	logic [8:0] i_sector_protect = 9'h000;
	logic i_temp_unprotect = 1'b0;
	logic [18:0] addr;
	logic [15:0] wdata, rdata, w;
	logic ce_n, we_n, oe_n, bclk, load_n, step_n, data_oe_n, done_n, sleep;
	int fails = 0;
	int comparisons = 0;
	int busy_cycles = 0;

	// Clock, and a count of busy cycles so short operations are never missed.
	always #20 i_core_clk = ~i_core_clk;
	always @(posedge i_core_clk) if (done_n === 1'b0) busy_cycles++;

	bfb_core DUT (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_addr(addr), .i_data(wdata),
		.o_data(rdata), .o_data_oe_n(data_oe_n), .i_chip_en_n(ce_n), .i_write_en_n(we_n),
		.i_out_en_n(oe_n), .i_burst_clk(bclk), .i_burst_start_load_n(load_n),
		.i_burst_step_n(step_n), .i_hw_reset_n(i_hw_reset_n), .i_low_supply(i_low_supply),
		.i_sector_protect(i_sector_protect), .i_temp_unprotect(i_temp_unprotect),
		.o_operation_done_n(done_n), .o_sleep(sleep));

	bfb_host_model host (.i_core_clk(i_core_clk), .i_data(rdata), .o_addr(addr),
		.o_data(wdata), .o_chip_en_n(ce_n), .o_write_en_n(we_n), .o_out_en_n(oe_n),
		.o_burst_clk(bclk), .o_burst_start_load_n(load_n), .o_burst_step_n(step_n));

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: %s saw %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// Bounded wait for the busy pin to reach a level.
	task automatic wait_pin(input logic lvl, input int lim);
		int n;
		n = 0;
		while (done_n !== lvl && n < lim) begin
			@(posedge i_core_clk);
			n++;
		end
		chk(done_n, lvl, "busy pin");
	endtask

	task automatic rd_chk(input logic [18:0] a, input logic [15:0] exp, input string what);
		host.rd(a, w);
		chk(w, exp, what);
	endtask

	task automatic pgm(input logic [18:0] a, input logic [15:0] d);
		host.wr(19'h00000, bfb_pkg::CMD_PROGRAM);
		host.wr(a, d);
		host.idle(12);
	endtask

	task automatic erase(input logic [18:0] a);
		host.wr(19'h00000, bfb_pkg::CMD_ERASE_SETUP);
		host.wr(a, bfb_pkg::CMD_SECTOR_ERASE);
		wait_pin(1'b0, 20);
	endtask

	task automatic t_program();
		int b0;
		chk(done_n, 1'b1, "idle busy pin");
		chk(data_oe_n, 1'b1, "idle output enable");
		erase(19'h03100);
		wait_pin(1'b1, 20000);
		rd_chk(19'h03000, bfb_pkg::ERASED_WORD, "erased word");
		b0 = busy_cycles;
		pgm(19'h03000, 16'h1234);
		chk(busy_cycles != b0, 1'b1, "program busy");
		rd_chk(19'h03000, 16'h1234, "programmed word");
		pgm(19'h0301e, 16'h0e0e);
		pgm(19'h0301f, 16'h0f0f);
		rd_chk(19'h0301e, 16'h0e0e, "second program");
		rd_chk(19'h0301f, 16'h0f0f, "third program");
		$display("test program done");
	endtask

	task automatic t_guard();
		int b0;
		b0 = busy_cycles;
		i_sector_protect <= 9'h004;
		pgm(19'h03000, 16'h0000);
		chk(busy_cycles == b0, 1'b1, "protected busy");
		rd_chk(19'h03000, 16'h1234, "protected word");
		i_temp_unprotect <= 1'b1;
		pgm(19'h03000, 16'h0204);
		rd_chk(19'h03000, 16'h0204, "unprotected word");
		i_temp_unprotect <= 1'b0;
		i_sector_protect <= 9'h000;
		i_low_supply <= 1'b1;
		b0 = busy_cycles;
		pgm(19'h03000, 16'h0004);
		chk(busy_cycles == b0, 1'b1, "undervoltage busy");
		rd_chk(19'h03000, 16'h0204, "undervoltage word");
		i_low_supply <= 1'b0;
		$display("test guard done");
	endtask

	task automatic t_erase();
		logic [15:0] s1, s2;
		erase(19'h02005);
		host.rd(19'h02005, s1);
		host.rd(19'h02005, s2);
		chk(s1 & 16'hffbf, 16'h0000, "erase status word");
		chk(s1[6] ^ s2[6], 1'b1, "toggle bit");
		host.wr(19'h00000, bfb_pkg::CMD_SUSPEND);
		host.idle(6);
		chk(done_n, 1'b1, "suspended busy pin");
		pgm(19'h03001, 16'h00ff);
		rd_chk(19'h03001, 16'h00ff, "suspend program");
		host.wr(19'h00000, bfb_pkg::CMD_RESUME);
		wait_pin(1'b0, 20);
		wait_pin(1'b1, 20000);
		rd_chk(19'h02005, bfb_pkg::ERASED_WORD, "erased after resume");
		rd_chk(19'h03000, 16'h0204, "neighbour sector");
		erase(19'h02005);
		i_hw_reset_n <= 1'b0;
		host.idle(3);
		i_hw_reset_n <= 1'b1;
		host.idle(4);
		chk(done_n, 1'b1, "aborted busy pin");
		rd_chk(19'h03001, 16'h00ff, "read after abort");
		$display("test erase done");
	endtask

	task automatic t_burst();
		host.wr(19'h00000, bfb_pkg::CMD_BURST_ON);
		host.burst(19'h0301e, 4);
		chk(data_oe_n, 1'b0, "burst output enable");
		chk(host.bw[0], 16'h0e0e, "burst start word");
		chk(host.bw[1], 16'h0f0f, "burst group end");
		chk(host.bw[2], 16'h0204, "burst wrap");
		chk(host.bw[3], 16'h00ff, "burst after wrap");
		host.wr(19'h00000, bfb_pkg::CMD_ASYNC);
		rd_chk(19'h0301f, 16'h0f0f, "async after burst");
		$display("test burst done");
	endtask

	task automatic t_sleep();
		host.rd(19'h03000, w);
		host.idle(12);
		chk(sleep, 1'b1, "sleep after stable address");
		rd_chk(19'h03000, 16'h0204, "read while asleep");
		host.rd(19'h0301f, w);
		chk(sleep, 1'b0, "wake on address change");
		$display("test sleep done");
	endtask

	// Main sequence: reset for five cycles, let the pin synchronisers fill, then run.
	initial begin
		repeat (5) @(posedge i_core_clk);
		i_rst_b <= 1'b1;
		repeat (3) @(posedge i_core_clk);
		t_program();
		t_guard();
		t_erase();
		t_burst();
		t_sleep();
		tally_and_finish();
	end

	// Watchdog: about three times the span of the two full sector erases and the short scenarios.
	initial begin
		#3000000;
		fails++;
		$display("mismatch at %0t: watchdog expired", $time);
		tally_and_finish();
	end
endmodule
